/* coherent_line_state_tracker.v */
// per-line coherency state keeping for a cached coherent master
`timescale 1ns/1ps
`default_nettype none
`include "line_state_defines.vh"

module coherent_line_state_tracker #(
    parameter ADDR_W = 32,
    parameter LINE_BYTES_LOG2 = 6,
    parameter INDEX_W = 4,
    parameter HAS_WRITE_EVICT = 0
) (
    // clock and reset
    input wire sys_clk,
    input wire rstn,
    // request from the cache core
    input wire req_valid,
    input wire [1:0] req_op,
    input wire [ADDR_W-1:0] req_addr,
    input wire req_snoop_unique,
    output wire req_ready,
    output reg done_pulse_q,
    output reg store_local_q,
    output reg wb_duty_q,
    output reg [2:0] done_state_q,
    // read address channel
    output reg arvalid_q,
    input wire arready,
    output reg [ADDR_W-1:0] araddr_q,
    output reg [1:0] ar_domain_q,
    output reg [3:0] ar_snoop_q,
    output reg [1:0] ar_bar_q,
    // read data channel end
    input wire rvalid,
    input wire rlast,
    input wire [3:0] rresp,
    output wire rready,
    output reg rack_q,
    // write address channel
    output reg awvalid_q,
    input wire awready,
    output reg [ADDR_W-1:0] awaddr_q,
    output reg [1:0] aw_domain_q,
    output reg [2:0] aw_snoop_q,
    output reg [1:0] aw_bar_q,
    output reg aw_unique_q,
    // write response end
    input wire bvalid,
    output wire bready,
    output reg wack_q,
    // snoop response
    output reg crvalid_q,
    input wire crready,
    output reg [4:0] crresp_q
);

    localparam DEPTH = 1 << INDEX_W;
    localparam TAG_W = ADDR_W - LINE_BYTES_LOG2 - INDEX_W;
    localparam S_IDLE = 3'h0;
    localparam S_AR = 3'h1;
    localparam S_R = 3'h2;
    localparam S_AW = 3'h3;
    localparam S_B = 3'h4;
    localparam S_CR = 3'h5;
    localparam S_DONE = 3'h6;

    // ========================================
    // reset release
    reg rst_a_q, rst_b_q;
    always @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            rst_a_q <= 1'b0;
            rst_b_q <= 1'b0;
        end else begin
            rst_a_q <= 1'b1;
            rst_b_q <= rst_a_q;
        end
    end
    wire rst_n = rst_b_q;

    // ========================================
    // helpers
    // line base with offset bits forced to zero
    function [ADDR_W-1:0] line_base;
        input [ADDR_W-1:0] a;
        begin
            line_base = (a >> LINE_BYTES_LOG2) << LINE_BYTES_LOG2;
        end
    endfunction

    function [INDEX_W-1:0] idx_of;
        input [ADDR_W-1:0] a;
        begin
            idx_of = a[LINE_BYTES_LOG2 +: INDEX_W];
        end
    endfunction

    // ========================================
    // line state and tag store
    reg [2:0] st_mem [0:DEPTH-1];
    reg [TAG_W-1:0] tag_mem [0:DEPTH-1];
    reg [2:0] fsm_q;
    reg [1:0] op_q;
    reg [ADDR_W-1:0] addr_q;
    reg snp_unique_q;
    reg [2:0] new_st_q;

    wire [INDEX_W-1:0] cur_idx = idx_of(addr_q);
    wire [TAG_W-1:0] cur_tag = addr_q[ADDR_W-1 -: TAG_W];
    wire tag_hit = tag_mem[cur_idx] == cur_tag;
    wire [2:0] cur_st = tag_hit ? st_mem[cur_idx] : `ST_RESET;
    wire present, st_local, st_notify, st_wb;

    line_state_decode u_decode (
        .st(cur_st),
        .present(present),
        .store_local(st_local),
        .store_notify(st_notify),
        .writeback_duty(st_wb)
    );

    // no request is taken while the internal reset copy still holds
    assign req_ready = (fsm_q == S_IDLE) & rst_n;
    assign rready = (fsm_q == S_R);
    assign bready = (fsm_q == S_B);

    // ========================================
    // controller
    // one request in flight keeps the state table free of races
    integer i;
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            fsm_q <= S_IDLE;
            op_q <= 2'h0;
            addr_q <= {ADDR_W{1'b0}};
            snp_unique_q <= 1'b0;
            new_st_q <= `ST_RESET;
            done_pulse_q <= 1'b0;
            store_local_q <= 1'b0;
            wb_duty_q <= 1'b0;
            done_state_q <= `ST_RESET;
            arvalid_q <= 1'b0;
            araddr_q <= {ADDR_W{1'b0}};
            ar_domain_q <= 2'h0;
            ar_snoop_q <= 4'h0;
            ar_bar_q <= 2'h0;
            rack_q <= 1'b0;
            awvalid_q <= 1'b0;
            awaddr_q <= {ADDR_W{1'b0}};
            aw_domain_q <= 2'h0;
            aw_snoop_q <= 3'h0;
            aw_bar_q <= 2'h0;
            aw_unique_q <= 1'b0;
            wack_q <= 1'b0;
            crvalid_q <= 1'b0;
            crresp_q <= 5'h00;
            for (i = 0; i < DEPTH; i = i + 1) begin
                st_mem[i] <= `ST_RESET;
                tag_mem[i] <= {TAG_W{1'b0}};
            end
        end else begin
            done_pulse_q <= 1'b0;
            rack_q <= 1'b0;
            wack_q <= 1'b0;
            case (fsm_q)
                S_IDLE: begin
                    if (req_valid) begin
                        op_q <= req_op;
                        addr_q <= line_base(req_addr);
                        snp_unique_q <= req_snoop_unique;
                        fsm_q <= S_DONE;
                        if (req_op == `OP_SNOOP) begin
                            fsm_q <= S_CR;
                        end else if (req_op == `OP_EVICT) begin
                            fsm_q <= S_AW;
                        end else begin
                            fsm_q <= S_AR;
                        end
                    end
                end
                S_AR: begin
                    if (!arvalid_q) begin
                        araddr_q <= addr_q;
                        ar_domain_q <= `DOMAIN_INNER;
                        ar_bar_q <= `BAR_NORMAL;
                        if (op_q == `OP_LOAD && present) begin
                            fsm_q <= S_DONE; // hit, no traffic
                            new_st_q <= cur_st;
                        end else if (op_q == `OP_STORE && st_local) begin
                            fsm_q <= S_DONE;
                            new_st_q <= 3'h7;
                        end else begin
                            arvalid_q <= 1'b1;
                            if (op_q == `OP_LOAD) begin
                                ar_snoop_q <= `RD_SNOOP_SHARED;
                            end else if (st_notify) begin
                                ar_snoop_q <= `RD_SNOOP_CLEAN_UNIQUE;
                            end else begin
                                ar_snoop_q <= `RD_SNOOP_UNIQUE;
                            end
                        end
                    end else if (arready) begin
                        arvalid_q <= 1'b0;
                        fsm_q <= S_R;
                    end
                end
                S_R: begin
                    if (rvalid && rlast) begin
                        rack_q <= 1'b1;
                        fsm_q <= S_DONE;
                        if (op_q == `OP_STORE) begin
                            // other copies removed, store now unique
                            new_st_q <= 3'h7;
                        end else begin
                            // take shared and dirty hints as given
                            new_st_q <= {1'b1,
                                ~rresp[`RESP_SHARED_BIT],
                                rresp[`RESP_DIRTY_BIT]};
                        end
                    end
                end
                S_AW: begin
                    if (!awvalid_q) begin
                        awaddr_q <= addr_q;
                        aw_domain_q <= `DOMAIN_INNER;
                        aw_bar_q <= `BAR_NORMAL;
                        aw_unique_q <= 1'b0;
                        new_st_q <= `ST_RESET;
                        if (st_wb) begin
                            awvalid_q <= 1'b1;
                            aw_snoop_q <= `WR_SNOOP_BACK;
                        end else if (present && HAS_WRITE_EVICT != 0) begin
                            awvalid_q <= 1'b1;
                            aw_snoop_q <= `WR_SNOOP_WREVICT;
                            aw_unique_q <= st_local;
                        end else begin
                            fsm_q <= S_DONE;
                        end
                    end else if (awready) begin
                        awvalid_q <= 1'b0;
                        fsm_q <= S_B;
                    end
                end
                S_B: begin
                    if (bvalid) begin
                        wack_q <= 1'b1;
                        fsm_q <= S_DONE;
                    end
                end
                S_CR: begin
                    if (!crvalid_q) begin
                        crvalid_q <= 1'b1;
                        // data transfer bit left low: no snoop data path
                        // a kept copy keeps the dirty duty, so it is only
                        // handed over when this copy is dropped
                        crresp_q <= {1'b0, present & ~snp_unique_q,
                            st_wb & snp_unique_q, 1'b0, 1'b0};
                        // unique snoop invalidates, others demote
                        if (snp_unique_q || !present) begin
                            new_st_q <= `ST_RESET;
                        end else begin
                            new_st_q <= {2'h2, cur_st[`ST_DIRTY_BIT]};
                        end
                    end else if (crready) begin
                        crvalid_q <= 1'b0;
                        fsm_q <= S_DONE;
                    end
                end
                S_DONE: begin
                    st_mem[cur_idx] <= new_st_q;
                    tag_mem[cur_idx] <= cur_tag;
                    done_state_q <= new_st_q;
                    store_local_q <= (op_q == `OP_STORE);
                    wb_duty_q <= new_st_q[`ST_VALID_BIT]
                        & new_st_q[`ST_DIRTY_BIT];
                    done_pulse_q <= 1'b1;
                    fsm_q <= S_IDLE;
                end
                default: begin
                    fsm_q <= S_IDLE;
                end
            endcase
        end
    end

endmodule
`default_nettype wire

/* line_state_defines.vh */
// constants for the coherent line state tracker
`ifndef LINE_STATE_DEFINES_VH
`define LINE_STATE_DEFINES_VH

// ========================================
// state bit positions within a line entry
`define ST_VALID_BIT 2
`define ST_UNIQUE_BIT 1
`define ST_DIRTY_BIT 0
`define ST_RESET 3'h0

// ========================================
// read snoop codes (4 bits)
`define RD_SNOOP_PLAIN 4'h0
`define RD_SNOOP_SHARED 4'h1
`define RD_SNOOP_UNIQUE 4'h7
`define RD_SNOOP_CLEAN_UNIQUE 4'hB
`define RD_SNOOP_MAKE_UNIQUE 4'hC

// ========================================
// write snoop codes (3 bits)
`define WR_SNOOP_PLAIN 3'h0
`define WR_SNOOP_BACK 3'h3
`define WR_SNOOP_EVICT 3'h4
`define WR_SNOOP_WREVICT 3'h5

// ========================================
// domain and barrier codes
`define DOMAIN_INNER 2'h1
`define DOMAIN_NONSHARE 2'h0
`define BAR_NORMAL 2'h0

// ========================================
// read response bit positions
`define RESP_DIRTY_BIT 2
`define RESP_SHARED_BIT 3

// ========================================
// operation codes from the cache core
`define OP_LOAD 2'h0
`define OP_STORE 2'h1
`define OP_EVICT 2'h2
`define OP_SNOOP 2'h3

`endif

/* line_state_decode.v */
// decode of one stored line state into its access duties
`timescale 1ns/1ps
`default_nettype none
`include "line_state_defines.vh"

module line_state_decode (
    // stored state bits
    input wire [2:0] st,
    // decoded duties
    output wire present,
    output wire store_local,
    output wire store_notify,
    output wire writeback_duty
);

    // ========================================
    // decode
    // valid low means invalid whatever the other bits hold
    assign present = st[`ST_VALID_BIT];
    assign store_local = present & st[`ST_UNIQUE_BIT];
    assign store_notify = present & ~st[`ST_UNIQUE_BIT];
    // shared clean never carries write-back duty
    assign writeback_duty = present & st[`ST_DIRTY_BIT];

endmodule
`default_nettype wire

/* line_tracker_sva.sv */
// concurrent checks on the line state tracker ports
`timescale 1ns/1ps
`default_nettype none
module line_tracker_sva #(
    parameter ADDR_W = 32,
    parameter LINE_BYTES_LOG2 = 6
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    // core side
    input wire logic req_ready,
    input wire logic done_pulse_q,
    input wire logic store_local_q,
    input wire logic wb_duty_q,
    input wire logic [2:0] done_state_q,
    // read side
    input wire logic arvalid_q,
    input wire logic arready,
    input wire logic [ADDR_W-1:0] araddr_q,
    input wire logic [1:0] ar_domain_q,
    input wire logic [3:0] ar_snoop_q,
    input wire logic rvalid,
    input wire logic rlast,
    input wire logic rready,
    input wire logic rack_q,
    // write side
    input wire logic awvalid_q,
    input wire logic [2:0] aw_snoop_q,
    input wire logic aw_unique_q,
    input wire logic bvalid,
    input wire logic bready,
    input wire logic wack_q,
    // snoop response
    input wire logic crvalid_q,
    input wire logic crready,
    input wire logic [4:0] crresp_q
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    // ==========================================
    // properties
    property p_idle;
        req_ready |-> !arvalid_q && !awvalid_q && !crvalid_q;
    endproperty
    a_idle: assert property (p_idle) else $error("busy while ready");
    // request must hold still until taken
    property p_ar_hold;
        arvalid_q && !arready |=> arvalid_q && $stable(araddr_q)
            && $stable(ar_snoop_q);
    endproperty
    a_ar_hold: assert property (p_ar_hold) else $error("ar dropped");
    property p_ar_line;
        arvalid_q |-> araddr_q[LINE_BYTES_LOG2-1:0] == 0
            && ar_domain_q == 2'h1;
    endproperty
    a_ar_line: assert property (p_ar_line) else $error("ar unaligned");
    property p_rack;
        rvalid && rlast && rready |-> ##[1:2] rack_q ##1 !rack_q;
    endproperty
    a_rack: assert property (p_rack) else $error("no read ack");
    property p_wack;
        bvalid && bready |-> ##[1:2] wack_q ##1 !wack_q;
    endproperty
    a_wack: assert property (p_wack) else $error("no write ack");
    property p_aw_code;
        awvalid_q |-> aw_snoop_q == 3'h3 && !aw_unique_q;
    endproperty
    a_aw_code: assert property (p_aw_code) else $error("aw code");
    // dirty duty only where valid and dirty
    property p_duty;
        done_pulse_q |-> wb_duty_q == (done_state_q[2] & done_state_q[0]);
    endproperty
    a_duty: assert property (p_duty) else $error("duty wrong");
    property p_store_unique;
        done_pulse_q && store_local_q |-> done_state_q == 3'b111;
    endproperty
    a_store_unique: assert property (p_store_unique)
        else $error("store not unique");
    property p_cr_one;
        crvalid_q && crready |=> !crvalid_q && crresp_q[1:0] == 2'h0;
    endproperty
    a_cr_one: assert property (p_cr_one) else $error("snoop resp");
    // a copy kept after a snoop keeps its dirty duty
    property p_cr_keep;
        crvalid_q && crresp_q[3] |-> !crresp_q[2];
    endproperty
    a_cr_keep: assert property (p_cr_keep) else $error("duty passed");
    // main scenarios seen
    c_store: cover property (done_pulse_q && store_local_q);
    c_snoop: cover property (crvalid_q && crready);
    c_evict: cover property (awvalid_q ##[1:20] wack_q);
endmodule
bind coherent_line_state_tracker line_tracker_sva #(.ADDR_W(ADDR_W),
    .LINE_BYTES_LOG2(LINE_BYTES_LOG2)) u_sva (.*);
`default_nettype wire

/* coherent_interconnect_model.sv */
// behavioural coherent interconnect facing the tracker
`timescale 1ns/1ps
`default_nettype none
module coherent_interconnect_model (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    // read address and data
    input wire logic arvalid,
    output logic arready,
    output logic rvalid,
    output logic rlast,
    output logic [3:0] rresp,
    input wire logic rready,
    // write address and response
    input wire logic awvalid,
    output logic awready,
    output logic bvalid,
    input wire logic bready,
    // snoop response
    input wire logic crvalid,
    output logic crready,
    // scenario controls
    input wire logic shared_resp,
    input wire logic slow
);
    logic [2:0] wait_q;
    logic pend;
    logic go;
    // slow mode holds arready, awready and crready back a few cycles; read data and write responses are not delayed
    assign pend = (arvalid & ~arready) | (awvalid & ~awready)
        | (crvalid & ~crready);
    assign go = !slow || wait_q >= 3'h4;
    assign rlast = rvalid;
    // released lines show the inverse rather than stale data
    assign rresp = rvalid ? {shared_resp, 3'h0} : {~shared_resp, 3'h7};
    always @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            {arready, awready, crready, rvalid, bvalid} <= 5'h00;
            wait_q <= 3'h0;
        end else begin
            wait_q <= (pend && wait_q != 3'h7) ? wait_q + 3'h1 : 3'h0;
            arready <= arvalid & ~arready & go;
            awready <= awvalid & ~awready & go;
            crready <= crvalid & ~crready & go;
            // one beat of data, plain response only on writes
            if (arvalid && arready) rvalid <= 1'b1;
            else if (rready) rvalid <= 1'b0;
            if (awvalid && awready) bvalid <= 1'b1;
            else if (bready) bvalid <= 1'b0;
        end
    end
endmodule
`default_nettype wire

/* coherent_line_state_tracker_tb_top.sv */
// self-checking bench for the coherent line state tracker
`timescale 1ns/1ps
`default_nettype none
`include "line_state_defines.vh"
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin fails++; \
    $display("[FAIL] %0t got %0h exp %0h", $time, a, e); end end
module coherent_line_state_tracker_tb_top;
    localparam int LB = 6;
    localparam logic [31:0] A = 32'h1234_5678;
    localparam logic [31:0] B = 32'h0000_0080;
    logic sys_clk, rstn, req_valid, req_snoop_unique, req_ready;
    logic done_pulse_q, store_local_q, wb_duty_q, arvalid_q, arready;
    logic rvalid, rlast, rready, rack_q, awvalid_q, awready, aw_unique_q;
    logic bvalid, bready, wack_q, crvalid_q, crready, shared_resp, slow;
    logic [1:0] req_op, ar_domain_q, ar_bar_q, aw_domain_q, aw_bar_q;
    logic [31:0] req_addr, araddr_q, awaddr_q, s_addr;
    logic [3:0] ar_snoop_q, rresp, s_ars;
    logic [2:0] done_state_q, aw_snoop_q, s_aws;
    logic [4:0] crresp_q;
    logic s_ar, s_aw, s_cr, s_rack, s_wack;
    int fails, n_tests;
    coherent_line_state_tracker #(.LINE_BYTES_LOG2(LB)) dut (.*);
    coherent_interconnect_model far (.sys_clk(sys_clk), .rstn(rstn),
        .arvalid(arvalid_q), .arready(arready), .rvalid(rvalid),
        .rlast(rlast), .rresp(rresp), .rready(rready),
        .awvalid(awvalid_q), .awready(awready), .bvalid(bvalid),
        .bready(bready), .crvalid(crvalid_q), .crready(crready),
        .shared_resp(shared_resp), .slow(slow));
    // ==========================================
    // one core request, watching the channels until done
    task automatic run_op(input logic [1:0] op, input logic [31:0] ad,
            input logic uq);
        int k;
        {s_ar, s_aw, s_cr, s_rack, s_wack} = 5'h00;
        @(posedge sys_clk);
        req_valid <= 1'b1;
        req_op <= op;
        req_addr <= ad;
        req_snoop_unique <= uq;
        k = 0;
        do begin @(negedge sys_clk); k++; end
            while (req_ready !== 1'b1 && k < 50);
        @(posedge sys_clk);
        req_valid <= 1'b0;
        k = 0;
        do begin
            @(negedge sys_clk);
            k++;
            if (arvalid_q === 1'b1) {s_ar, s_ars, s_addr} = {1'b1,
                ar_snoop_q, araddr_q};
            if (awvalid_q === 1'b1) {s_aw, s_aws} = {1'b1, aw_snoop_q};
            s_cr |= crvalid_q === 1'b1;
            s_rack |= rack_q === 1'b1;
            s_wack |= wack_q === 1'b1;
        end while (done_pulse_q !== 1'b1 && k < 200);
        `CHK(done_pulse_q, 1'b1)
    endtask
    // ==========================================
    // scenarios
    task t_load_unique;
        run_op(`OP_LOAD, A, 1'b0);
        `CHK(s_ars, 4'h1)
        `CHK({ar_domain_q, ar_bar_q}, 4'h4)
        `CHK(s_addr, A & ~((32'h1 << LB) - 32'h1))
        `CHK(s_rack, 1'b1)
        `CHK(done_state_q, 3'b110)
    endtask
    task t_store_local;
        run_op(`OP_STORE, A, 1'b0);
        `CHK(s_ar, 1'b0)
        `CHK({store_local_q, wb_duty_q, done_state_q}, 5'h1F)
    endtask
    task t_share_snoop;
        run_op(`OP_SNOOP, A, 1'b0);
        `CHK(s_cr, 1'b1)
        `CHK({wb_duty_q, done_state_q}, 4'hD)
        `CHK(crresp_q, 5'h08)
    endtask
    task t_store_shared;
        run_op(`OP_STORE, A, 1'b0);
        `CHK(s_ars, 4'hB)
        `CHK(done_state_q, 3'b111)
    endtask
    task t_evict_dirty;
        slow <= 1'b1;
        run_op(`OP_EVICT, A, 1'b0);
        `CHK({s_aw, s_aws, aw_unique_q}, 5'h16)
        `CHK({s_wack, done_state_q}, 4'h8)
        `CHK({awaddr_q, aw_domain_q, aw_bar_q}, {A & ~32'h3F, 4'h4})
    endtask
    task t_load_shared;
        shared_resp <= 1'b1;
        run_op(`OP_LOAD, B, 1'b0);
        `CHK({wb_duty_q, done_state_q}, 4'h4)
        `CHK(done_state_q[1], 1'b0)
        run_op(`OP_EVICT, B, 1'b0);
        `CHK({s_aw, done_state_q}, 4'h0)
    endtask
    task t_unique_snoop;
        {shared_resp, slow} <= 2'b00;
        run_op(`OP_LOAD, A, 1'b0);
        run_op(`OP_SNOOP, A, 1'b1);
        `CHK({s_cr, done_state_q}, 4'h8)
        `CHK(crresp_q, 5'h00)
    endtask
    task results;
        $display("checks %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // ==========================================
    // clock, reset, sequence and watchdog
    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end
    initial begin
        {rstn, req_valid, req_snoop_unique, shared_resp, slow} = 5'h00;
        {req_op, req_addr, fails, n_tests} = '0;
        repeat (4) @(posedge sys_clk);
        rstn <= 1'b1;
        t_load_unique();
        t_store_local();
        t_share_snoop();
        t_store_shared();
        t_evict_dirty();
        t_load_shared();
        t_unique_snoop();
        results();
    end
    // a hang ends the run through the same verdict
    initial begin
        #125000;
        fails++;
        results();
    end
endmodule
`default_nettype wire
